// *** design/adc_bus_regs.sv ***
`timescale 1ns/1ps
module adc_bus_regs #(
	parameter logic [15:0][11:0] CHAN_MAP = adc_bus_pkg::CHAN_MAP_DEF
) (
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic BUS_CLK_I,
	input wire logic RST_N_I,
	input wire logic CS_N_I,
	input wire logic RW_I,
	input wire logic REGISTER_CHOICE_I,
	input wire logic [7:0] DATA_I,
	input wire logic [5:0] SHARED_INPUT_LEVELS_I,
	input wire logic [7:0] CORE_RESULT_I,
	output logic [7:0] DATA_O,
	output logic DATA_OE_O,
	output logic [11:0] MUX_SEL_O,
	output logic ACQUIRE_O,
	output logic CONVERT_O
);

	logic [18:0] pins;
	logic [18:0] st;
	logic bclk;
	logic pin_rst_n;
	logic cs_n;
	logic rw;
	logic choice;
	logic [7:0] din;
	logic [5:0] shared;
	logic bclk_d_r;
	logic rise;
	logic fall;
	logic soft_rst;
	logic ptr_ls_r;
	logic ms_written_r;
	logic start_bit_r;
	logic write_done;
	logic [3:0] chan_r;
	logic [7:0] result_r;
	logic eoc_r;
	logic [4:0] cnt_r;
	logic finish;
	logic [15:0] rd_word;
	adc_bus_pkg::conv_state_e state_r;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign pins = {BUS_CLK_I, RST_N_I, CS_N_I, RW_I, REGISTER_CHOICE_I,
		DATA_I, SHARED_INPUT_LEVELS_I};

	pin_sync #(
		.WIDTH(adc_bus_pkg::SYNC_W)
	) u_sync (
		.clk_i(REF_CLK_I),
		.rst_i(SYS_RST_I),
		.pin_i(pins),
		.stable_o(st)
	);

	assign bclk = st[18];
	assign pin_rst_n = st[17];
	assign cs_n = st[16];
	assign rw = st[15];
	assign choice = st[14];
	assign din = st[13:6];
	assign shared = st[5:0];

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			bclk_d_r <= 1'b0;
		end else begin
			bclk_d_r <= bclk;
		end
	end

	assign rise = bclk & ~bclk_d_r;
	assign fall = ~bclk & bclk_d_r;
	assign soft_rst = SYS_RST_I | ~pin_rst_n;

	// ----------------------------------------
	// byte pointer and control write
	// ----------------------------------------
	// full write complete
	assign write_done = fall & ~cs_n & ~rw & ptr_ls_r & ms_written_r;

	always_ff @(posedge REF_CLK_I) begin
		if (soft_rst) begin
			ptr_ls_r <= 1'b0;
			ms_written_r <= 1'b0;
		end else if (rise & cs_n) begin
			ptr_ls_r <= 1'b0;
			ms_written_r <= 1'b0;
		end else if (fall & ~cs_n) begin
			ptr_ls_r <= 1'b1;
			if (!ptr_ls_r) begin
				ms_written_r <= ~rw;
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (soft_rst) begin
			start_bit_r <= 1'b0;
		end else if (fall & ~cs_n & ~rw & ~ptr_ls_r) begin
			start_bit_r <= din[adc_bus_pkg::START_BIT_POS];
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			chan_r <= adc_bus_pkg::CHAN_RST;
		end else if (write_done) begin
			chan_r <= din[adc_bus_pkg::CHAN_LSB +: adc_bus_pkg::CHAN_W];
		end
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	assign finish = (state_r == adc_bus_pkg::CONV_RUN) & rise
		& (cnt_r == adc_bus_pkg::CONV_CYCLES - 5'd1);

	always_ff @(posedge REF_CLK_I) begin
		if (soft_rst) begin
			state_r <= adc_bus_pkg::CONV_IDLE;
			cnt_r <= 5'd0;
		end else if (write_done & start_bit_r) begin
			state_r <= adc_bus_pkg::CONV_ACQ;
			cnt_r <= 5'd0;
		end else if (rise) begin
			case (state_r)
				adc_bus_pkg::CONV_ACQ: begin
					cnt_r <= cnt_r + 5'd1;
					if (cnt_r == adc_bus_pkg::ACQ_CYCLES - 5'd1) begin
						state_r <= adc_bus_pkg::CONV_RUN;
					end
				end
				adc_bus_pkg::CONV_RUN: begin
					cnt_r <= cnt_r + 5'd1;
					if (finish) begin
						state_r <= adc_bus_pkg::CONV_IDLE;
						cnt_r <= 5'd0;
					end
				end
				adc_bus_pkg::CONV_IDLE: begin
					cnt_r <= 5'd0;
				end
				default: begin
					state_r <= adc_bus_pkg::CONV_IDLE;
					cnt_r <= 5'd0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// result and status
	// ----------------------------------------
	// result survives pin reset
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			result_r <= adc_bus_pkg::RESULT_RST;
		end else if (finish) begin
			result_r <= CORE_RESULT_I;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			eoc_r <= 1'b0;
		end else if (finish) begin
			eoc_r <= 1'b1;
		end else if (write_done) begin
			eoc_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_comb begin
		rd_word = 16'h0000;
		if (choice == adc_bus_pkg::CHOICE_CONV) begin
			rd_word[8 + adc_bus_pkg::EOC_BIT_POS] = eoc_r;
			rd_word[7:0] = result_r;
		end else begin
			rd_word[8 + adc_bus_pkg::SHARED_LSB +: adc_bus_pkg::SHARED_W] =
				shared;
			rd_word[adc_bus_pkg::CHAN_LSB +: adc_bus_pkg::CHAN_W] = chan_r;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (soft_rst) begin
			DATA_O <= 8'h00;
			DATA_OE_O <= 1'b0;
		end else begin
			DATA_OE_O <= bclk & ~cs_n & rw;
			DATA_O <= ptr_ls_r ? rd_word[7:0] : rd_word[15:8];
		end
	end

	// ----------------------------------------
	// analog core controls
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		if (soft_rst) begin
			MUX_SEL_O <= 12'h000;
			ACQUIRE_O <= 1'b0;
			CONVERT_O <= 1'b0;
		end else begin
			MUX_SEL_O <= CHAN_MAP[chan_r];
			ACQUIRE_O <= (state_r == adc_bus_pkg::CONV_ACQ);
			CONVERT_O <= (state_r == adc_bus_pkg::CONV_RUN);
		end
	end

endmodule

// *** inc/adc_bus_pkg.sv ***
// Overview of operation
// - read drives MS byte while clock high
// - next rising edge drives LS byte
// - further transfers keep returning LS byte
// - control word ignores unused bits
// - start bit begins conversion after write
// - channel field selects multiplexer input
// - end-of-conversion flag set on completion
// - complete control write clears flag
// - other conversion MS bits read zero
// - result sits in conversion LS byte
// - digital register reports shared pin levels
// - digital register reports current channel
// - acquisition plus conversion 30 clocks, acquisition 10
// - deselect returns pointer to MS byte
// - new command aborts and restarts acquisition
package adc_bus_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int BYTE_W = 8;
	localparam int CHAN_W = 4;
	localparam int SHARED_W = 6;
	localparam int MUX_W = 12;
	localparam int SYNC_W = 19;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int START_BIT_POS = 7;
	localparam int EOC_BIT_POS = 7;
	localparam int CHAN_LSB = 0;
	localparam int SHARED_LSB = 0;

	// ----------------------------------------
	// register_choice codes
	// ----------------------------------------
	localparam logic CHOICE_CONV = 1'b0;
	localparam logic CHOICE_SHARED = 1'b1;

	// ----------------------------------------
	// timing in device clock cycles
	// ----------------------------------------
	localparam logic [4:0] ACQ_CYCLES = 5'd10;
	localparam logic [4:0] CONV_CYCLES = 5'd30;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RESULT_RST = 8'h00;
	localparam logic [3:0] CHAN_RST = 4'h0;

	// ----------------------------------------
	// default channel decode: code n selects input n for 0-11, codes 12-15 select none
	// ----------------------------------------
	localparam logic [15:0][11:0] CHAN_MAP_DEF = {
		12'h000, 12'h000, 12'h000, 12'h000,
		12'h800, 12'h400, 12'h200, 12'h100,
		12'h080, 12'h040, 12'h020, 12'h010,
		12'h008, 12'h004, 12'h002, 12'h001
	};

	typedef enum logic [2:0] {
		CONV_IDLE = 3'b001,
		CONV_ACQ = 3'b010,
		CONV_RUN = 3'b100
	} conv_state_e;

endpackage

// *** design/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] stable_o
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// ----------------------------------------
	// three stages; accept once second and third agree
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_r[g] <= 1'b0;
					s2_r[g] <= 1'b0;
					s3_r[g] <= 1'b0;
					stable_o[g] <= 1'b0;
				end else begin
					s1_r[g] <= pin_i[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g]) begin
						stable_o[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

endmodule

// *** verif/adc_bus_monitor.sv ***
`timescale 1ns/1ps
module adc_bus_monitor (
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic BUS_CLK_I,
	input wire logic RST_N_I,
	input wire logic CS_N_I,
	input wire logic RW_I,
	input wire logic [7:0] DATA_O,
	input wire logic DATA_OE_O,
	input wire logic ACQUIRE_O,
	input wire logic CONVERT_O
);
	logic bclk_d_r;
	logic acq_d_r;
	logic [5:0] rise_cnt_r;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// ----
	// bus clock rises since acquisition began
	// ----
	always_ff @(posedge REF_CLK_I) begin
		bclk_d_r <= BUS_CLK_I;
		acq_d_r <= ACQUIRE_O;
		if (ACQUIRE_O && !acq_d_r) begin
			rise_cnt_r <= 6'h00;
		end else if (BUS_CLK_I && !bclk_d_r) begin
			rise_cnt_r <= rise_cnt_r + 6'h01;
		end
	end
	property p_rst_idle;
		!RST_N_I [*8] |-> !DATA_OE_O && !ACQUIRE_O && !CONVERT_O;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("outputs active in reset");
	property p_oe_rise;
		$rose(DATA_OE_O) |-> BUS_CLK_I && RW_I && !CS_N_I;
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("drive outside read clock high");
	property p_oe_fall;
		$fell(DATA_OE_O) |-> !BUS_CLK_I;
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("release while clock high");
	property p_oe_stand;
		$rose(DATA_OE_O) |=> (DATA_OE_O && $stable(DATA_O)) [*8];
	endproperty
	a_oe_stand: assert property (p_oe_stand)
		else $error("read byte not held");
	property p_cs_idle;
		CS_N_I [*8] |-> !DATA_OE_O;
	endproperty
	a_cs_idle: assert property (p_cs_idle)
		else $error("drive while deselected");
	property p_acq_start;
		$rose(ACQUIRE_O) |-> !CS_N_I && !RW_I && !BUS_CLK_I;
	endproperty
	a_acq_start: assert property (p_acq_start)
		else $error("acquisition without write");
	property p_acq_len;
		$fell(ACQUIRE_O) && CS_N_I && RST_N_I |->
			rise_cnt_r == 6'd10 ##[0:1] CONVERT_O;
	endproperty
	a_acq_len: assert property (p_acq_len)
		else $error("acquisition length wrong");
	property p_conv_len;
		$fell(CONVERT_O) && CS_N_I && RST_N_I |-> rise_cnt_r == 6'd30;
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion length wrong");
endmodule

bind adc_bus_regs adc_bus_monitor mon (
	.REF_CLK_I(REF_CLK_I),
	.SYS_RST_I(SYS_RST_I),
	.BUS_CLK_I(BUS_CLK_I),
	.RST_N_I(RST_N_I),
	.CS_N_I(CS_N_I),
	.RW_I(RW_I),
	.DATA_O(DATA_O),
	.DATA_OE_O(DATA_OE_O),
	.ACQUIRE_O(ACQUIRE_O),
	.CONVERT_O(CONVERT_O)
);

// *** verif/host_model.sv ***
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk_i,
	output logic bclk_o,
	output logic rst_n_o,
	output logic cs_n_o,
	output logic rw_o,
	output logic choice_o,
	output logic [7:0] data_o
);
	initial begin
		bclk_o = 1'b0;
		rst_n_o = 1'b1;
		cs_n_o = 1'b1;
		rw_o = 1'b1;
		choice_o = 1'b0;
		data_o = 8'h00;
		forever begin
			repeat (10) @(posedge ref_clk_i);
			#1 bclk_o = ~bclk_o;
		end
	end
	task automatic pulse_rst();
		@(negedge bclk_o);
		rst_n_o = 1'b0;
		repeat (4) @(posedge bclk_o);
		rst_n_o = 1'b1;
	endtask
	// select mid-phase so no edge coincides with it
	task automatic xfer(input logic rd, input logic sel, input int n,
		input logic [15:0] w);
		@(negedge bclk_o);
		repeat (5) @(posedge ref_clk_i);
		#1 cs_n_o = 1'b0;
		rw_o = rd;
		choice_o = sel;
		for (int i = 0; i < n; i++) begin
			@(posedge bclk_o);
			data_o = rd ? ~data_o : (i == 0) ? w[15:8] : w[7:0];
			@(negedge bclk_o);
		end
		if (!rd)
			@(posedge bclk_o);
		repeat (5) @(posedge ref_clk_i);
		#1 cs_n_o = 1'b1;
		data_o = ~data_o;
		@(posedge bclk_o);
		@(posedge bclk_o);
	endtask
endmodule

// *** verif/adc_peripheral_bus_registers_bench.sv ***
`timescale 1ns/1ps
module adc_peripheral_bus_registers_bench;
	logic ref_clk, sys_rst, bclk, rst_n, cs_n, rw, rs, oe, acq, conv;
	logic [7:0] h_data, core, data_o, res, bus;
	logic [5:0] levels;
	logic [11:0] mux;
	logic [31:0] seed;
	logic [3:0] ch;
	logic [7:0] exp_q[$];
	int n_mismatch, check_count;
	assign bus = oe ? data_o : h_data;
	host_model host (.ref_clk_i(ref_clk), .bclk_o(bclk), .rst_n_o(rst_n),
		.cs_n_o(cs_n), .rw_o(rw), .choice_o(rs), .data_o(h_data));
	adc_bus_regs dut (.REF_CLK_I(ref_clk), .SYS_RST_I(sys_rst),
		.BUS_CLK_I(bclk), .RST_N_I(rst_n), .CS_N_I(cs_n), .RW_I(rw),
		.REGISTER_CHOICE_I(rs), .DATA_I(bus), .SHARED_INPUT_LEVELS_I(levels),
		.CORE_RESULT_I(core), .DATA_O(data_o), .DATA_OE_O(oe),
		.MUX_SEL_O(mux), .ACQUIRE_O(acq), .CONVERT_O(conv));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check(input string nm, input logic [15:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task test_done();
		check("left", 16'(exp_q.size()), 16'h0000);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task rd(input logic c, input int n, input logic [7:0] ms, ls);
		exp_q.push_back(ms);
		repeat (n - 1) exp_q.push_back(ls);
		host.xfer(1'b1, c, n, 16'h0000);
	endtask
	task automatic wait_lvl(input logic lvl);
		int k;
		k = 0;
		while (conv !== lvl && k < 1000) begin
			@(posedge ref_clk);
			k++;
		end
		check("conv", {15'h0, conv}, {15'h0, lvl});
	endtask
	task wait_conv();
		wait_lvl(1'b1);
		wait_lvl(1'b0);
	endtask
	always @(negedge bclk) begin
		if (oe === 1'b1) begin
			res = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
			check("read", {8'h00, data_o}, {8'h00, res});
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		levels = 6'h00;
		core = 8'h00;
		seed = 32'hfc09;
		repeat (8) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		host.pulse_rst();
		rd(1'b0, 2, 8'h00, adc_bus_pkg::RESULT_RST);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			ch = (i == 3) ? 4'hf : 4'(seed[15:0] % 16'd12);
			core = seed[23:16];
			levels = seed[29:24];
			host.xfer(1'b0, 1'b0, 2, {1'b1, seed[6:0], seed[11:8], ch});
			check("mux", {4'h0, mux},
				{4'h0, adc_bus_pkg::CHAN_MAP_DEF[ch]});
			rd(1'b0, 1, 8'h00, 8'h00);
			wait_conv();
			rd(1'b0, 3, 8'h80, core);
			rd(1'b1, 2, {2'b00, levels}, {4'h0, ch});
		end
		// one-byte write: no clear, no start, channel kept
		host.xfer(1'b0, 1'b0, 1, 16'h8007);
		check("one", {14'h0, acq, conv}, 16'h0000);
		rd(1'b0, 2, 8'h80, core);
		rd(1'b1, 2, {2'b00, levels}, 8'h0f);
		seed = lfsr(seed);
		core = seed[7:0];
		host.xfer(1'b0, 1'b0, 2, 16'h8003);
		wait_lvl(1'b1);
		host.xfer(1'b0, 1'b0, 2, 16'h8005);
		check("acq", {15'h0, acq}, 16'h0001);
		wait_conv();
		rd(1'b0, 2, 8'h80, core);
		host.xfer(1'b0, 1'b0, 2, 16'h7ff2);
		repeat (40) @(posedge ref_clk);
		check("idle", {14'h0, acq, conv}, 16'h0000);
		rd(1'b0, 2, 8'h00, core);
		rd(1'b1, 2, {2'b00, levels}, 8'h02);
		host.xfer(1'b0, 1'b0, 2, 16'h8001);
		wait_lvl(1'b1);
		host.pulse_rst();
		check("rst", {13'h0, acq, conv, oe}, 16'h0000);
		rd(1'b0, 2, 8'h00, core);
		test_done();
	end
endmodule
